// >>> swp_pkg.sv
// Purpose: shared constants and types of the single-wire slave physical layer
// Assumes: 100 MHz reference clock, all times given in ns
// Notes:   cycle counts are derived from the times; least times round up, longest round down
package swp_pkg;

    // ************************************************************
    // clock and counter geometry
    // ************************************************************
    localparam int          CLK_NS    = 10;
    localparam int          CNT_W     = 17;
    localparam logic [16:0] CNT_MAX   = 17'h1FFFF;

    // ************************************************************
    // line timing in ns (standard / overdrive)
    // ************************************************************
    localparam int LONG_RST_NS   = 690000;  // reset_low_time that leaves overdrive
    localparam int OD_SHORT_NS   = 80000;   // longest reset_low_time that keeps overdrive
    localparam int STD_RST_NS    = 440000;  // low time taken as reset, standard
    localparam int OD_RST_NS     = 40000;   // low time taken as reset, overdrive
    localparam int STD_PWAIT_NS  = 15000;   // presence_wait_time
    localparam int OD_PWAIT_NS   = 2000;
    localparam int STD_PLOW_NS   = 60000;   // presence_low_time
    localparam int OD_PLOW_NS    = 8000;
    localparam int STD_SAMP_NS   = 30000;   // write sample point after the fall
    localparam int OD_SAMP_NS    = 3000;
    localparam int STD_HOLD_NS   = 30000;   // read-zero pulldown, longest
    localparam int OD_HOLD_NS    = 3000;
    localparam int STD_REH_NS    = 5000;    // rising_edge_holdoff
    localparam int OD_REH_NS     = 1000;
    localparam int STD_FILT_NS   = 50;      // extra fall filtering, standard only

    // ************************************************************
    // derived cycle counts
    // ************************************************************
    localparam logic [16:0] LONG_RST_CYC  = 17'((LONG_RST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] OD_SHORT_CYC  = 17'(OD_SHORT_NS / CLK_NS);
    localparam logic [16:0] STD_RST_CYC   = 17'((STD_RST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] OD_RST_CYC    = 17'((OD_RST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] STD_PWAIT_CYC = 17'((STD_PWAIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] OD_PWAIT_CYC  = 17'((OD_PWAIT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] STD_PLOW_CYC  = 17'((STD_PLOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] OD_PLOW_CYC   = 17'((OD_PLOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] STD_SAMP_CYC  = 17'((STD_SAMP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] OD_SAMP_CYC   = 17'((OD_SAMP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] STD_HOLD_CYC  = 17'(STD_HOLD_NS / CLK_NS);
    localparam logic [16:0] OD_HOLD_CYC   = 17'(OD_HOLD_NS / CLK_NS);
    localparam logic [16:0] STD_REH_CYC   = 17'((STD_REH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [16:0] OD_REH_CYC    = 17'((OD_REH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0]  FILT_CYC      = 3'((STD_FILT_NS + CLK_NS - 1) / CLK_NS);

    // ************************************************************
    // crc polynomials, reflected for lsb-first shifting
    // ************************************************************
    localparam logic [7:0]  CRC8_POLY_REF  = 8'h8C;    // x^8+x^5+x^4+1
    localparam logic [15:0] CRC16_POLY_REF = 16'hA001; // x^16+x^15+x^2+1

    // ************************************************************
    // line state machine
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SLOT,
        ST_RST,
        ST_PWAIT,
        ST_PLOW,
        ST_HOLD
    } swp_state_t;

endpackage : swp_pkg

// >>> swp_crc_if.sv
// Purpose: carrier between the line engine and one crc generator
// Assumes: one clock domain
// Notes:   clr wins over shift in the same cycle
`timescale 1ns/1ps
`default_nettype none
interface swp_crc_if #(parameter int W = 8);
    logic         clr;
    logic         shift;
    logic         din;
    logic [W-1:0] q;

    modport ctl (output clr, output shift, output din, input q);
    modport gen (input clr, input shift, input din, output q);
endinterface : swp_crc_if
`default_nettype wire

// >>> swp_crc_gen.sv
// Purpose: lsb-first crc shift register of any width
// Assumes: one bit per shift pulse
// Notes:   output is the raw register; inversion is done by the user
`timescale 1ns/1ps
`default_nettype none
module swp_crc_gen #(
    parameter int           W        = 8,
    parameter logic [W-1:0] POLY_REF = '0
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    // crc control
    swp_crc_if.gen    bus
);
    import swp_pkg::*;

    typedef struct packed {
        logic [W-1:0] crc;
    } swp_crcst_t;

    swp_crcst_t st_ff;
    swp_crcst_t nxt_st;

    // galois step, feedback from the bit leaving the low end
    always_comb begin
        nxt_st = st_ff;
        if (bus.clr) begin
            nxt_st.crc = '0;
        end else if (bus.shift) begin
            nxt_st.crc = (st_ff.crc >> 1) ^ ((st_ff.crc[0] ^ bus.din) ? POLY_REF : '0);
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.q = st_ff.crc;

    crc_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        bus.clr |=> (bus.q == '0))
        else $error("crc not cleared");
endmodule : swp_crc_gen
`default_nettype wire

// >>> swp_fall_filter.sv
// Purpose: low-pass on the falling edge that opens a slot
// Assumes: line input already synchronous
// Notes:   rising edges pass at once; bypass removes the filter
`timescale 1ns/1ps
`default_nettype none
module swp_fall_filter (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    // line and mode
    input  wire logic line_i,
    input  wire logic bypass_i,
    // filtered low level
    output logic      low_o
);
    import swp_pkg::*;

    typedef struct packed {
        logic [2:0] cnt;
        logic       low;
    } swp_filt_t;

    swp_filt_t st_ff;
    swp_filt_t nxt_st;

    // count consecutive low samples, release on first high
    always_comb begin
        nxt_st = st_ff;
        if (line_i) begin
            nxt_st.cnt = 3'h0;
            nxt_st.low = 1'b0;
        end else if (bypass_i) begin
            nxt_st.low = 1'b1;
        end else if (st_ff.cnt + 3'h1 >= FILT_CYC) begin
            nxt_st.low = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign low_o = st_ff.low;

    filt_std_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        ($rose(low_o) && !$past(bypass_i)) |-> ($past(!line_i, 1) && $past(!line_i, 5)))
        else $error("standard fall passed too early");
    filt_od_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (bypass_i && !line_i) |=> low_o)
        else $error("overdrive fall was filtered");
endmodule : swp_fall_filter
`default_nettype wire

// >>> swp_phy.sv
// Purpose: slave physical layer of a single-wire open-drain bus with crc generators
// Assumes: line_i synchronous to ref_clk_i; command layer drives overdrive set and crc gating
// Notes:   line is open drain: line_o is always low, line_oe_o pulls the wire
//
// Overview of operation
// - master starts every signal; device drives alone only for presence
// - standard timing unless overdrive set; overdrive timing then applies everywhere
// - a reset low of 690 us or more returns to standard speed
// - in overdrive a reset low of at most 80 us keeps overdrive
// - after reset release wait presence delay, then pull low for presence time
// - reset high covers presence and recovery; data accepted right after
// - each time slot carries exactly one bit in one direction
// - falling edge starts internal timer for write sample and read hold
// - a recovery interval follows each slot before the next
// - read zero: device holds line low by own timer; read one: released
// - extra falling-edge filtering at standard speed, bypassed in overdrive
// - glitches inside the rising holdoff are ignored; later lows open slots
// - 8-bit crc x^8+x^5+x^4+1 over identity, sent non-inverted
// - 16-bit crc x^16+x^15+x^2+1, always sent inverted
// - first memory read pass: clear crc, shift command, address, data, no password
// - later memory read passes: clear crc, shift only that pass's data
// - scratchpad write crc over command, address, data; sent at end offset
// - scratchpad read crc over command, address, status, data; sent at end
// - overdrive set by skip 3Ch or matching 69h until long reset
// - each rom command is one byte after presence
`timescale 1ns/1ps
`default_nettype none
module swp_phy
    import swp_pkg::*;
#(
    parameter logic [16:0] LONG_RST_P = swp_pkg::LONG_RST_CYC,
    parameter logic [16:0] STD_RST_P  = swp_pkg::STD_RST_CYC,
    parameter logic [16:0] STD_PLOW_P = swp_pkg::STD_PLOW_CYC,
    parameter logic [16:0] OD_SHORT_P = swp_pkg::OD_SHORT_CYC
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // open-drain line
    input  wire logic        line_i,
    output logic             line_o,
    output logic             line_oe_o,
    // bit level to the command layer
    input  wire logic        tx_en_i,
    input  wire logic        tx_bit_i,
    output logic             rx_bit_o,
    output logic             rx_valid_o,
    output logic             reset_seen_o,
    // speed control
    input  wire logic        od_set_i,
    output logic             overdrive_flag_o,
    // crc control
    input  wire logic        crc8_clear_i,
    input  wire logic        crc8_en_i,
    input  wire logic        crc16_clear_i,
    input  wire logic        crc16_en_i,
    output logic [7:0]       crc8_o,
    output logic [15:0]      crc16_inv_o
);
    import swp_pkg::*;

    typedef struct packed {
        swp_state_t  state;
        logic [16:0] cnt;
        logic        od;
        logic        oe;
        logic        tx_zero;
        logic        sampled;
        logic        rx_bit;
        logic        rx_valid;
        logic        rst_pulse;
        logic [7:0]  crc8;
        logic [15:0] crc16_inv;
    } swp_phy_t;

    swp_phy_t    st_ff;
    swp_phy_t    nxt_st;
    logic        fall_low;
    logic [16:0] samp_cyc;
    logic [16:0] hold_cyc;
    logic [16:0] rst_cyc;
    logic [16:0] pwait_cyc;
    logic [16:0] plow_cyc;
    logic [16:0] reh_cyc;

    swp_crc_if #(.W(8))  c8 ();
    swp_crc_if #(.W(16)) c16 ();

    // ************************************************************
    // submodules
    // ************************************************************

    // slot-start detector, filter only at standard speed
    swp_fall_filter u_filt (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .line_i    (line_i),
        .bypass_i  (st_ff.od),
        .low_o     (fall_low)
    );

    swp_crc_gen #(.W(8), .POLY_REF(CRC8_POLY_REF)) u_crc8 (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .bus       (c8)
    );

    swp_crc_gen #(.W(16), .POLY_REF(CRC16_POLY_REF)) u_crc16 (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .bus       (c16)
    );

    // crc fed one bit per slot with the bit seen on the line
    assign c8.clr    = crc8_clear_i;
    assign c8.shift  = st_ff.rx_valid & crc8_en_i;
    assign c8.din    = st_ff.rx_bit;
    assign c16.clr   = crc16_clear_i;
    assign c16.shift = st_ff.rx_valid & crc16_en_i;
    assign c16.din   = st_ff.rx_bit;

    // ************************************************************
    // speed-dependent timing
    // ************************************************************

    // every waveform follows the current speed
    always_comb begin
        samp_cyc  = st_ff.od ? OD_SAMP_CYC  : STD_SAMP_CYC;
        hold_cyc  = st_ff.od ? OD_HOLD_CYC  : STD_HOLD_CYC;
        rst_cyc   = st_ff.od ? OD_RST_CYC   : STD_RST_P;
        pwait_cyc = st_ff.od ? OD_PWAIT_CYC : STD_PWAIT_CYC;
        plow_cyc  = st_ff.od ? OD_PLOW_CYC  : STD_PLOW_P;
        reh_cyc   = st_ff.od ? OD_REH_CYC   : STD_REH_CYC;
    end

    // ************************************************************
    // line state machine
    // ************************************************************

    // next state of the line engine
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.rx_valid  = 1'b0;
        nxt_st.rst_pulse = 1'b0;
        nxt_st.cnt       = (st_ff.cnt == CNT_MAX) ? st_ff.cnt : st_ff.cnt + 17'h00001;
        nxt_st.crc8      = c8.q;
        nxt_st.crc16_inv = ~c16.q;
        case (st_ff.state)
            ST_IDLE: begin
                // line released while waiting for the master
                nxt_st.oe = 1'b0;
                if (fall_low) begin
                    // timer starts on the slot's falling edge
                    nxt_st.state   = ST_SLOT;
                    nxt_st.cnt     = 17'h00001;
                    nxt_st.sampled = 1'b0;
                    nxt_st.tx_zero = tx_en_i & ~tx_bit_i;
                    nxt_st.oe      = tx_en_i & ~tx_bit_i;
                end
            end
            ST_SLOT: begin
                // read zero: hold low until own timer ends
                if (st_ff.oe && st_ff.cnt >= hold_cyc) begin
                    nxt_st.oe = 1'b0;
                end
                // write bit taken at the sample point of own timer
                if (!st_ff.sampled && st_ff.cnt == samp_cyc) begin
                    nxt_st.rx_bit   = line_i;
                    nxt_st.rx_valid = 1'b1;
                    nxt_st.sampled  = 1'b1;
                end
                // a low held past the reset limit turns the slot into a reset
                if (!line_i && st_ff.cnt >= rst_cyc) begin
                    nxt_st.state = ST_RST;
                end else if (line_i && st_ff.sampled && !st_ff.oe) begin
                    nxt_st.state = ST_HOLD;
                    nxt_st.cnt   = 17'h00000;
                end
            end
            ST_RST: begin
                // long reset drops overdrive, short keeps it
                if (st_ff.cnt >= LONG_RST_P) begin
                    nxt_st.od = 1'b0;
                end
                if (line_i) begin
                    nxt_st.state     = ST_PWAIT;
                    nxt_st.cnt       = 17'h00000;
                    nxt_st.rst_pulse = 1'b1;
                end
            end
            ST_PWAIT: begin
                // presence delay after the line came back high
                if (st_ff.cnt >= pwait_cyc) begin
                    nxt_st.state = ST_PLOW;
                    nxt_st.cnt   = 17'h00000;
                    nxt_st.oe    = 1'b1;
                end
            end
            ST_PLOW: begin
                // presence pulse length from own timer
                if (st_ff.cnt >= plow_cyc) begin
                    nxt_st.state = ST_HOLD;
                    nxt_st.cnt   = 17'h00000;
                    nxt_st.oe    = 1'b0;
                end
            end
            ST_HOLD: begin
                // ignore the line during the rising holdoff
                if (st_ff.cnt >= reh_cyc && line_i) begin
                    nxt_st.state = ST_IDLE;
                end
            end
            default: begin
                // unused code falls back to idle, line released
                nxt_st.state = ST_IDLE;
                nxt_st.oe    = 1'b0;
            end
        endcase
        // overdrive set by the command layer wins over a clear
        if (od_set_i) begin
            nxt_st.od = 1'b1;
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff       <= '0;
            st_ff.state <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // all outputs straight from the state register, except line_o which is tied low
    assign line_o           = 1'b0;
    assign line_oe_o        = st_ff.oe;
    assign rx_bit_o         = st_ff.rx_bit;
    assign rx_valid_o       = st_ff.rx_valid;
    assign reset_seen_o     = st_ff.rst_pulse;
    assign overdrive_flag_o = st_ff.od;
    assign crc8_o           = st_ff.crc8;
    assign crc16_inv_o      = st_ff.crc16_inv;

    // ************************************************************
    // checks
    // ************************************************************

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence rst_release_s;
        (st_ff.state == ST_RST) && line_i;
    endsequence

    sequence slot_open_s;
        (st_ff.state == ST_IDLE) && fall_low && tx_en_i && !tx_bit_i;
    endsequence

    // end of the presence pulse
    sequence presence_done_s;
        $fell(st_ff.state == ST_PLOW);
    endsequence

    // inside the rising holdoff
    sequence hold_early_s;
        (st_ff.state == ST_HOLD) && (st_ff.cnt < reh_cyc);
    endsequence

    drive_source_a: assert property (
        line_oe_o |-> ((st_ff.state == ST_PLOW) || ((st_ff.state == ST_SLOT) && st_ff.tx_zero)))
        else $error("line driven outside presence or read zero");

    presence_start_a: assert property (
        $rose(st_ff.state == ST_PLOW) |-> ($past(st_ff.state) == ST_PWAIT) && line_oe_o)
        else $error("presence low without wait");

    reset_end_a: assert property (
        rst_release_s |=> st_ff.rst_pulse ##1 (st_ff.state == ST_PWAIT) && !line_oe_o)
        else $error("reset release not followed by presence wait");

    od_long_a: assert property (
        ((st_ff.state == ST_RST) && (st_ff.cnt >= LONG_RST_P) && !od_set_i) |=> !overdrive_flag_o)
        else $error("long reset kept overdrive");

    od_short_a: assert property (
        (rst_release_s and (st_ff.od && (st_ff.cnt <= OD_SHORT_P))) |=> overdrive_flag_o)
        else $error("short overdrive reset dropped overdrive");

    od_set_a: assert property (
        od_set_i |=> overdrive_flag_o)
        else $error("overdrive set lost");

    sample_time_a: assert property (
        $rose(rx_valid_o) |-> ($past(st_ff.cnt) == ($past(st_ff.od) ? OD_SAMP_CYC : STD_SAMP_CYC)))
        else $error("bit sampled at wrong time");

    read_zero_a: assert property (
        slot_open_s |=> line_oe_o [*2])
        else $error("read zero not driven");

    holdoff_a: assert property (
        $fell(st_ff.state == ST_HOLD) |-> ($past(st_ff.cnt) >= $past(reh_cyc)) && $past(line_i))
        else $error("holdoff left too early");

    // holdoff keeps the engine deaf to the line
    hold_stay_a: assert property (
        hold_early_s |=> (st_ff.state == ST_HOLD))
        else $error("low inside holdoff was taken");

    // own timer end points of each waveform step
    presence_wait_a: assert property (
        $rose(st_ff.state == ST_PLOW) |-> ($past(st_ff.cnt) == $past(pwait_cyc)))
        else $error("presence wait has wrong length");

    presence_len_a: assert property (
        presence_done_s |-> ($past(st_ff.cnt) == $past(plow_cyc)))
        else $error("presence low has wrong length");

    read_release_a: assert property (
        ($fell(line_oe_o) && ($past(st_ff.state) == ST_SLOT)) |-> ($past(st_ff.cnt) == $past(hold_cyc)))
        else $error("read zero released at wrong time");

    reset_detect_a: assert property (
        $rose(st_ff.state == ST_RST) |-> ($past(st_ff.cnt) >= $past(rst_cyc)) && !$past(line_i))
        else $error("reset taken before the reset limit");

    one_bit_a: assert property (
        rx_valid_o |-> ($past(st_ff.state) == ST_SLOT) && !$past(st_ff.sampled))
        else $error("more than one bit in a slot");

endmodule : swp_phy
`default_nettype wire

// >>> swp_bus_master.sv
// Purpose: bus master model for the single-wire line
// Assumes: open-drain wire with pull-up, resolved in the bench
// Notes:   drives at the falling clock edge; wire released between frames
`timescale 1ns/1ps
`default_nettype none
module swp_bus_master (
    // clock and wire
    input  wire logic ref_clk_i,
    input  wire logic wire_i,
    // pulldown request
    output var logic  pull_o
);
    // ************************************************************
    // line tasks
    // ************************************************************
    initial pull_o = 1'b0;

    // low for low cycles, optional 20-cycle glitch, idle until total
    task automatic slot(input int low, input int total, input int glitch);
        for (int c = 0; c < total; c++) begin
            @(negedge ref_clk_i);
            pull_o <= (c < low) || (glitch > 0 && c >= glitch && c < glitch + 20);
        end
    endtask : slot

    // reset low, sample presence at samp after release, idle to total
    task automatic bus_reset(input int low, input int samp, input int total, output logic pres);
        slot(low, low + samp, 0);
        @(posedge ref_clk_i);
        pres = wire_i;
        slot(0, total - samp, 0);
    endtask : bus_reset
endmodule : swp_bus_master
`default_nettype wire

// >>> swp_phy_test.sv
// Purpose: self-checking bench of the single-wire slave layer
// Assumes: shortened reset and presence counts
// Notes:   slots run at fixed master timing; bit pulses are counted
`timescale 1ns/1ps
`default_nettype none
module swp_phy_test;
    import swp_pkg::*;
    typedef struct {logic ten; logic tbit; int low; int glitch; int npulse; logic exp;} swp_row_t;
    logic        ref_clk_i, reset_i, tx_en_i, tx_bit_i, od_set_i, pull, pres;
    logic        crc8_clear_i, crc8_en_i, crc16_clear_i, crc16_en_i;
    logic        line_o, line_oe_o, rx_bit_o, rx_valid_o, reset_seen_o, overdrive_flag_o;
    logic [7:0]  crc8_o, e8, h8;
    logic [15:0] crc16_inv_o, e16;
    int          errors, cmp_count, pulses, seen;
    wire logic   line = ~(pull | line_oe_o);
    // ************************************************************
    // slot table: 0-4 standard, 5-10 overdrive
    // ************************************************************
    swp_row_t rows[11] = '{'{0,0,100,0,1,1}, '{0,0,3500,0,1,0}, '{1,1,100,0,1,1}, '{1,0,100,0,1,0},
        '{0,0,3,0,0,0}, '{0,0,10,0,1,1}, '{0,0,350,0,1,0}, '{1,1,10,0,1,1}, '{1,0,10,0,1,0},
        '{0,0,3,330,1,1}, '{0,0,3,420,2,1}};

    swp_phy #(.LONG_RST_P(17'h01770), .STD_RST_P(17'h00FA0), .STD_PLOW_P(17'h0003C),
        .OD_SHORT_P(17'h01388)) i_swp_phy (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .line_i(line), .line_o(line_o), .line_oe_o(line_oe_o), .tx_en_i(tx_en_i),
        .tx_bit_i(tx_bit_i), .rx_bit_o(rx_bit_o), .rx_valid_o(rx_valid_o),
        .reset_seen_o(reset_seen_o), .od_set_i(od_set_i), .overdrive_flag_o(overdrive_flag_o),
        .crc8_clear_i(crc8_clear_i), .crc8_en_i(crc8_en_i), .crc16_clear_i(crc16_clear_i),
        .crc16_en_i(crc16_en_i), .crc8_o(crc8_o), .crc16_inv_o(crc16_inv_o));
    swp_bus_master i_swp_bus_master (.ref_clk_i(ref_clk_i), .wire_i(line), .pull_o(pull));

    // clock and pulse counters
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (rx_valid_o === 1'b1) pulses++;
        if (reset_seen_o === 1'b1) seen++;
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        errors++;
        end_sim();
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic run_row(input int i, input int total);
        int p0;
        @(negedge ref_clk_i);
        tx_en_i = rows[i].ten;
        tx_bit_i = rows[i].tbit;
        p0 = pulses;
        i_swp_bus_master.slot(rows[i].low, total, rows[i].glitch);
        check(16'(pulses - p0), 16'(rows[i].npulse));
        if (rows[i].npulse > 0) check(rx_bit_o, rows[i].exp);
    endtask : run_row

    // write a byte lsb first and update expected crcs
    task automatic send_byte(input logic [7:0] b);
        for (int k = 0; k < 8; k++) begin
            i_swp_bus_master.slot(b[k] ? 10 : 350, 600, 0);
            e8 = (e8 >> 1) ^ ((e8[0] ^ b[k]) ? 8'h8C : 8'h00);
            e16 = (e16 >> 1) ^ ((e16[0] ^ b[k]) ? 16'hA001 : 16'h0000);
        end
    endtask : send_byte
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {reset_i, tx_en_i, tx_bit_i, od_set_i} = 4'h8;
        {crc8_clear_i, crc8_en_i, crc16_clear_i, crc16_en_i} = 4'h0;
        {errors, cmp_count, pulses, seen} = 128'h0;
        repeat (12) @(posedge ref_clk_i);
        check(line_oe_o, 1'b0);
        check(overdrive_flag_o, 1'b0);
        @(negedge ref_clk_i);
        reset_i = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        check(crc16_inv_o, 16'hFFFF);
        i_swp_bus_master.bus_reset(4500, 1530, 2500, pres);
        check(pres, 1'b0);
        check(16'(seen), 16'h0001);
        check(line_o, 1'b0);
        for (int i = 0; i < 5; i++) run_row(i, 4600);
        // overdrive entry, then short reset keeps it
        @(negedge ref_clk_i);
        od_set_i = 1'b1;
        @(negedge ref_clk_i);
        od_set_i = 1'b0;
        check(overdrive_flag_o, 1'b1);
        i_swp_bus_master.bus_reset(4200, 600, 1500, pres);
        check(pres, 1'b0);
        check(overdrive_flag_o, 1'b1);
        for (int i = 5; i < 10; i++) run_row(i, 600);
        run_row(10, 1000);
        // crc over two bytes at overdrive
        @(negedge ref_clk_i);
        {crc8_clear_i, crc16_clear_i} = 2'h3;
        @(negedge ref_clk_i);
        {crc8_clear_i, crc16_clear_i, crc8_en_i, crc16_en_i} = 4'h3;
        e8 = 8'h00;
        e16 = 16'h0000;
        send_byte(8'hCC);
        send_byte(8'h3C);
        check(crc8_o, e8);
        check(crc16_inv_o, ~e16);
        // later pass: crc16 cleared alone, crc8 gated off and held
        h8 = e8;
        e16 = 16'h0000;
        {crc8_en_i, crc16_clear_i} = 2'h1;
        @(negedge ref_clk_i);
        crc16_clear_i = 1'b0;
        send_byte(8'hA5);
        check(crc8_o, h8);
        check(crc16_inv_o, ~e16);
        {crc8_en_i, crc16_en_i} = 2'h0;
        // long reset back to standard speed
        i_swp_bus_master.bus_reset(6500, 1530, 2500, pres);
        check(overdrive_flag_o, 1'b0);
        check(pres, 1'b0);
        run_row(4, 4600);
        run_row(1, 4600);
        end_sim();
    end
endmodule : swp_phy_test
`default_nettype wire
